// ---- verilog/lsu_core.sv ----
// Load/store instruction decoder and executor
`default_nettype none
module lsu_core (
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  input  wire logic                         i_start,
  input  wire logic [lsu_pkg::WORD_W-1:0]   i_instr,
  input  wire logic [lsu_pkg::WORD_W-1:0]   i_word2,
  input  wire logic [lsu_pkg::ADDR_W-1:0]   i_pc,
  input  wire logic                         i_mem_ack,
  input  wire logic [lsu_pkg::WORD_W-1:0]   i_mem_rdata,
  output logic                              o_mem_req,
  output logic                              o_mem_we,
  output logic      [lsu_pkg::ADDR_W-1:0]   o_mem_addr,
  output logic      [lsu_pkg::WORD_W-1:0]   o_mem_wdata,
  output logic                              o_busy,
  output logic                              o_done,
  output logic                              o_illegal,
  output logic      [lsu_pkg::WORD_W-1:0]   o_acc,
  output logic      [lsu_pkg::WORD_W-1:0]   o_sec,
  output logic      [lsu_pkg::WORD_W-1:0]   o_idx
);
  localparam int AW = lsu_pkg::ADDR_W;

  lsu_pkg::lsu_state_t     state_reg, state_next;
  logic [AW-1:0]           addr_reg, addr_next;
  logic [1:0]              sel_reg, sel_next;
  logic                    store_reg, store_next;
  logic [2:0]              lvl_reg, lvl_next;
  logic                    post_reg, post_next;
  logic [AW-1:0]           pidx_reg, pidx_next;
  logic                    done_reg, done_next;
  logic                    ill_reg, ill_next;

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  // Index register value picked by a mode code
  function automatic logic [AW-1:0] idx_of(input logic [2:0] mode,
                                           input logic [15:0] xr,
                                           input logic [15:0] br);
    idx_of = (mode == lsu_pkg::MODE_XIDX) ? xr[AW-1:0] :
             (mode == lsu_pkg::MODE_BIDX) ? br[AW-1:0] : '0;
  endfunction

  // Field split of both forms
  wire       is_ext   = i_instr[15:6] == lsu_pkg::EXT_PATTERN;
  wire [2:0] one_op   = i_instr[14:12];
  wire [2:0] one_mode = i_instr[11:9];
  wire [8:0] one_fld  = i_instr[8:0];
  wire [2:0] ext_op   = i_instr[5:3];
  wire [2:0] ext_mode = i_instr[2:0];
  wire [2:0] op       = is_ext ? ext_op : one_op;
  wire       op_ok    = (is_ext || !i_instr[15]) &&
                        op != lsu_pkg::OP_NONE && op != lsu_pkg::OP_FOREIGN;
  wire       is_store = op[2];
  wire [1:0] target   = op[1:0];
  wire       is_lit   = is_ext && !ext_mode[2];
  wire       is_post  = i_instr[lsu_pkg::POST_BIT];
  wire [AW-1:0] w2addr = i_word2[AW-1:0];

  // One-word effective base address and indirection
  wire [AW-1:0] one_fld_w = {{(AW-9){1'b0}}, one_fld};
  wire [AW-1:0] one_base  =
      !one_mode[2]                    ? {{(AW-11){1'b0}}, one_mode[1:0],
                                         one_fld} :
      (one_mode == lsu_pkg::MODE_REL) ? AW'(i_pc + one_fld_w) :
      (one_mode == lsu_pkg::MODE_IND) ? one_fld_w :
      AW'(one_fld_w + idx_of(one_mode, o_idx, o_sec));
  wire one_ind = one_mode == lsu_pkg::MODE_IND;

  // Long form: top bit of second word asks for indirection
  wire ext_ind  = i_word2[15];
  wire ext_post = is_post && ext_ind &&
                  (ext_mode == lsu_pkg::MODE_XIDX ||
                   ext_mode == lsu_pkg::MODE_BIDX);
  wire [AW-1:0] ext_base =
      (ext_mode == lsu_pkg::MODE_IND) ? w2addr :
      (ext_mode == lsu_pkg::MODE_REL) ? AW'(i_pc + w2addr) :
      ext_post ? w2addr :
      AW'(w2addr + idx_of(ext_mode, o_idx, o_sec));

  wire [AW-1:0] base    = is_ext ? ext_base : one_base;
  wire          use_ind = is_ext ? ext_ind : one_ind;
  wire [2:0]    limit   = is_ext ? lsu_pkg::IND_LIMIT_TWO
                                 : lsu_pkg::IND_LIMIT_ONE;
  wire take = i_start && state_reg == lsu_pkg::ST_IDLE;

  // ****************************************************************
  // Register bank writes
  // ****************************************************************
  // Literal loads write at once; memory loads write on the answer
  wire lit_load = take && op_ok && is_lit && !is_store;
  wire mem_load = state_reg == lsu_pkg::ST_OPER && i_mem_ack &&
                  !store_reg;
  wire       wr_en   = lit_load || mem_load;
  wire [1:0] wr_sel  = lit_load ? target : sel_reg;
  wire [15:0] wr_dat = lit_load ? i_word2 : i_mem_rdata;

  lsu_regs u_regs (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_we   (wr_en),
    .i_sel  (wr_sel),
    .i_data (wr_dat),
    .o_acc  (o_acc),
    .o_sec  (o_sec),
    .o_idx  (o_idx)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state, address chain and completion pulses
  always_comb
  begin
    state_next = state_reg;
    addr_next  = addr_reg;
    sel_next   = sel_reg;
    store_next = store_reg;
    lvl_next   = lvl_reg;
    post_next  = post_reg;
    pidx_next  = pidx_reg;
    done_next  = 1'b0;
    ill_next   = 1'b0;
    unique case (state_reg)
      lsu_pkg::ST_IDLE:
      begin
        if (i_start)
        begin
          sel_next   = target;
          store_next = is_store;
          post_next  = ext_post;
          pidx_next  = idx_of(ext_mode, o_idx, o_sec);
          lvl_next   = limit;
          if (!op_ok)
          begin
            ill_next   = 1'b1;
            state_next = lsu_pkg::ST_END;
          end
          else if (is_lit && !is_store)
            state_next = lsu_pkg::ST_END;
          else if (is_lit)
          begin
            addr_next  = i_pc;
            state_next = lsu_pkg::ST_OPER;
          end
          else
          begin
            addr_next  = base;
            state_next = use_ind ? lsu_pkg::ST_CHAIN : lsu_pkg::ST_OPER;
          end
        end
      end
      lsu_pkg::ST_CHAIN:
      begin
        if (i_mem_ack)
        begin
          lvl_next = 3'(lvl_reg - 3'h1);
          if (i_mem_rdata[15] && lvl_reg > 3'h1)
            addr_next = i_mem_rdata[AW-1:0];
          else
          begin
            addr_next  = AW'(i_mem_rdata[AW-1:0] +
                             (post_reg ? pidx_reg : '0));
            state_next = lsu_pkg::ST_OPER;
          end
        end
      end
      lsu_pkg::ST_OPER:
      begin
        if (i_mem_ack)
          state_next = lsu_pkg::ST_END;
      end
      lsu_pkg::ST_END:
      begin
        done_next  = 1'b1;
        state_next = lsu_pkg::ST_IDLE;
      end
    endcase
  end

  // State and working registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg <= lsu_pkg::ST_IDLE;
      addr_reg  <= '0;
      sel_reg   <= '0;
      store_reg <= 1'b0;
      lvl_reg   <= '0;
      post_reg  <= 1'b0;
      pidx_reg  <= '0;
      done_reg  <= 1'b0;
      ill_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      sel_reg   <= sel_next;
      store_reg <= store_next;
      lvl_reg   <= lvl_next;
      post_reg  <= post_next;
      pidx_reg  <= pidx_next;
      done_reg  <= done_next;
      ill_reg   <= ill_next || (ill_reg && state_reg == lsu_pkg::ST_END);
    end
  end

  // ****************************************************************
  // Memory port and status
  // ****************************************************************
  // Stores write only in the operand phase
  wire [15:0] store_val = (sel_reg == lsu_pkg::SEL_ACC) ? o_acc :
                          (sel_reg == lsu_pkg::SEL_SEC) ? o_sec : o_idx;
  assign o_mem_req   = state_reg == lsu_pkg::ST_CHAIN ||
                       state_reg == lsu_pkg::ST_OPER;
  assign o_mem_we    = state_reg == lsu_pkg::ST_OPER && store_reg;
  assign o_mem_addr  = addr_reg;
  assign o_mem_wdata = store_val;
  assign o_busy      = state_reg != lsu_pkg::ST_IDLE;
  assign o_done      = done_reg;
  assign o_illegal   = done_reg && ill_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_lit_load_acc: assert property (
    take && lit_load && target == lsu_pkg::SEL_ACC |=> o_acc == $past(i_word2))
    else $error("literal load did not reach accumulator");
  a_lit_store_addr: assert property (
    take && op_ok && is_lit && is_store |=>
      o_mem_we && o_mem_addr == $past(i_pc))
    else $error("literal store not aimed at second word");
  a_direct_addr: assert property (
    take && op_ok && !is_ext && !one_mode[2] |=>
      o_mem_addr == {4'h0, $past(one_mode[1:0]), $past(one_fld)})
    else $error("direct one-word address wrong");
  a_ext_direct: assert property (
    take && op_ok && is_ext && ext_mode == lsu_pkg::MODE_IND && !ext_ind |=>
      state_reg == lsu_pkg::ST_OPER && o_mem_addr == $past(w2addr))
    else $error("long direct address wrong");
  a_chain_limit: assert property (
    state_reg == lsu_pkg::ST_CHAIN |-> lvl_reg >= 3'h1 && lvl_reg <= 3'h5)
    else $error("indirect chain exceeded its depth");
  a_store_keeps: assert property (
    o_busy && store_reg |-> !wr_en)
    else $error("store changed a register");
  a_store_writes: assert property (
    state_reg == lsu_pkg::ST_OPER && store_reg && o_mem_req |->
      o_mem_we && o_mem_wdata == store_val)
    else $error("store phase did not write");
  a_load_target: assert property (
    mem_load && sel_reg == lsu_pkg::SEL_IDX |=>
      o_idx == $past(i_mem_rdata) && $stable(o_acc))
    else $error("load hit wrong register");
  a_req_hold: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("memory request dropped before answer");
  a_done_end: assert property (
    take && !op_ok |=> ##1 o_done && o_illegal)
    else $error("foreign code not flagged");

  c_lit_load:  cover property (take && lit_load);
  c_lit_store: cover property (take && is_lit && is_store && op_ok);
  c_chain:     cover property (state_reg == lsu_pkg::ST_CHAIN ##1
                               state_reg == lsu_pkg::ST_CHAIN);
  c_mem_load:  cover property (mem_load);
endmodule
`default_nettype wire

// ---- shared/lsu_pkg.sv ----
// Constants and types shared by the load/store instruction unit
`default_nettype none
package lsu_pkg;
  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int ADDR_W = 15;

  // ****************************************************************
  // Instruction fields and codes
  // ****************************************************************
  localparam logic [9:0] EXT_PATTERN  = 10'h030; // First word bits 15:6
  localparam logic [2:0] OP_NONE      = 3'h0;
  localparam logic [2:0] OP_LOAD_ACC  = 3'h1;
  localparam logic [2:0] OP_LOAD_SEC  = 3'h2;
  localparam logic [2:0] OP_LOAD_IDX  = 3'h3;
  localparam logic [2:0] OP_FOREIGN   = 3'h4;
  localparam logic [2:0] OP_STORE_ACC = 3'h5;
  localparam logic [2:0] OP_STORE_SEC = 3'h6;
  localparam logic [2:0] OP_STORE_IDX = 3'h7;
  localparam logic [2:0] MODE_REL     = 3'h4;
  localparam logic [2:0] MODE_XIDX    = 3'h5;
  localparam logic [2:0] MODE_BIDX    = 3'h6;
  localparam logic [2:0] MODE_IND     = 3'h7;
  localparam int         POST_BIT     = 7;

  // ****************************************************************
  // Register selects and counts
  // ****************************************************************
  localparam logic [1:0] SEL_ACC = 2'h1;
  localparam logic [1:0] SEL_SEC = 2'h2;
  localparam logic [1:0] SEL_IDX = 2'h3;
  localparam logic [2:0] IND_LIMIT_ONE = 3'h5;
  localparam logic [2:0] IND_LIMIT_TWO = 3'h4;
  localparam logic [15:0] REG_RESET = 16'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_CHAIN, ST_OPER, ST_END} lsu_state_t;
endpackage
`default_nettype wire

// ---- verilog/lsu_regs.sv ----
// Accumulator, secondary and index register bank
`default_nettype none
module lsu_regs (
  input  wire logic                         i_clk,
  input  wire logic                         i_nrst,
  input  wire logic                         i_we,
  input  wire logic [1:0]                   i_sel,
  input  wire logic [lsu_pkg::WORD_W-1:0]   i_data,
  output logic      [lsu_pkg::WORD_W-1:0]   o_acc,
  output logic      [lsu_pkg::WORD_W-1:0]   o_sec,
  output logic      [lsu_pkg::WORD_W-1:0]   o_idx
);
  logic [lsu_pkg::WORD_W-1:0] bank_reg [1:3];

  // ****************************************************************
  // One write port, each register written only when selected
  // ****************************************************************
  genvar g;
  generate
    for (g = 1; g <= 3; g++)
    begin : g_bank
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
          bank_reg[g] <= lsu_pkg::REG_RESET;
        else if (i_we && i_sel == 2'(g))
          bank_reg[g] <= i_data;
      end
    end
  endgenerate

  // Register contents out
  assign o_acc = bank_reg[lsu_pkg::SEL_ACC];
  assign o_sec = bank_reg[lsu_pkg::SEL_SEC];
  assign o_idx = bank_reg[lsu_pkg::SEL_IDX];
endmodule
`default_nettype wire

// ---- tb/lsu_mem_model.sv ----
// Behavioural main memory that answers the unit's operand port
`default_nettype none
module lsu_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [14:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [3:0]  i_delay,
  output logic             o_ack,
  output logic      [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [15:0] mem [0:32767];
  logic [3:0]  wait_reg;
  logic [15:0] junk_reg;
  int          wr_count = 0;

  // Answer once a request has waited the chosen number of cycles
  assign o_ack   = i_req && (wait_reg == i_delay);
  // Outside a read answer the data lines carry a changing pattern
  assign o_rdata = (o_ack && !i_we) ? mem[i_addr] : junk_reg;

  // Wait counter, write port and idle pattern
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wait_reg <= 4'h0;
      junk_reg <= 16'h5aa5;
    end
    else
    begin
      junk_reg <= ~junk_reg;
      wait_reg <= (i_req && !o_ack) ? wait_reg + 4'h1 : 4'h0;
      if (o_ack && i_we)
      begin
        mem[i_addr] <= i_wdata;
        wr_count    <= wr_count + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/load_store_instruction_unit_tb.sv ----
// Self-checking bench for the load/store instruction unit
`default_nettype none
module load_store_instruction_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] w2;
    logic [14:0] pc;
    logic [3:0]  dly;
    logic [2:0]  kind;
    logic [14:0] addr;
    logic [15:0] val;
  } lsu_row_t;
  logic        i_clk;
  logic        i_nrst;
  logic        i_start;
  logic [15:0] i_instr;
  logic [15:0] i_word2;
  logic [14:0] i_pc;
  logic [3:0]  dly;
  logic        mem_ack;
  logic [15:0] mem_rdata;
  logic        mem_req;
  logic        mem_we;
  logic [14:0] mem_addr;
  logic [15:0] mem_wdata;
  logic        busy;
  logic        done;
  logic        illegal;
  logic [15:0] acc;
  logic [15:0] sec;
  logic [15:0] idx;
  logic [15:0] e_acc;
  logic [15:0] e_sec;
  logic [15:0] e_idx;
  int          n_mismatch;
  int          samples_checked;
  int          wr_before;
  // Kind: 0 refused, 1..3 load into register, 5 one memory write
  lsu_row_t rows [22] = '{
    '{16'h0c08,16'ha5c3,15'h0000,4'h0,3'h1,15'h0000,16'ha5c3},
    '{16'h0c10,16'h3c5a,15'h0000,4'h1,3'h2,15'h0000,16'h3c5a},
    '{16'h0c18,16'h0100,15'h0000,4'h0,3'h3,15'h0000,16'h0100},
    '{16'h0c28,16'h7fff,15'h0456,4'h0,3'h5,15'h0456,16'ha5c3},
    '{16'h0c30,16'h7fff,15'h0457,4'h2,3'h5,15'h0457,16'h3c5a},
    '{16'h0c38,16'h0000,15'h0458,4'h1,3'h5,15'h0458,16'h0100},
    '{16'h1645,16'h0000,15'h0000,4'h0,3'h1,15'h0645,16'h1234},
    '{16'h2810,16'h0000,15'h1000,4'h2,3'h2,15'h1010,16'h5678},
    '{16'h3a20,16'h0000,15'h0000,4'h1,3'h3,15'h0120,16'h0200},
    '{16'h5c04,16'h0000,15'h0000,4'h0,3'h5,15'h567c,16'h1234},
    '{16'h6e30,16'h0000,15'h0000,4'h1,3'h5,15'h0300,16'h5678},
    '{16'h71ff,16'h0000,15'h0000,4'h3,3'h5,15'h01ff,16'h0200},
    '{16'h0c0f,16'h2345,15'h0000,4'h0,3'h1,15'h2345,16'h9abc},
    '{16'h0c14,16'h0100,15'h0400,4'h1,3'h2,15'h0500,16'hdef0},
    '{16'h0c1f,16'h8600,15'h0000,4'h0,3'h3,15'h0700,16'h0042},
    '{16'h0c2f,16'h3000,15'h0000,4'h2,3'h5,15'h3000,16'h9abc},
    '{16'h0c37,16'h3001,15'h0000,4'h0,3'h5,15'h3001,16'hdef0},
    '{16'h0c3f,16'h3002,15'h0000,4'h1,3'h5,15'h3002,16'h0042},
    '{16'h4123,16'h0000,15'h0000,4'h0,3'h0,15'h0000,16'h0000},
    '{16'h1e40,16'h0000,15'h0000,4'h0,3'h1,15'h0045,16'h0c0c},
    '{16'h0c17,16'h8050,15'h0000,4'h1,3'h2,15'h0054,16'h0d0d},
    '{16'h0c0d,16'h0100,15'h0000,4'h2,3'h1,15'h0142,16'h1357}
  };

  // ****************************************************************
  // Design and memory partner
  // ****************************************************************
  lsu_core i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(i_start),
    .i_instr(i_instr), .i_word2(i_word2), .i_pc(i_pc),
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_mem_req(mem_req),
    .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
    .o_busy(busy), .o_done(done), .o_illegal(illegal),
    .o_acc(acc), .o_sec(sec), .o_idx(idx));
  lsu_mem_model i_mem (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(mem_req),
    .i_we(mem_we), .i_addr(mem_addr), .i_wdata(mem_wdata), .i_delay(dly),
    .o_ack(mem_ack), .o_rdata(mem_rdata));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compare one value and count it
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Print the counts and the verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Wait for the completion pulse under a bound
  task automatic wait_done();
    int k;
    for (k = 0; k < 100; k++)
    begin
      @(negedge i_clk);
      if (done === 1'b1)
        break;
    end
    if (k == 100)
    begin
      n_mismatch++;
      $display("wrong value done expected 1 seen 0");
      end_of_test();
    end
  endtask

  // Offer one instruction for one cycle and wait for its end
  task automatic run(input lsu_row_t r);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_instr <= r.instr;
    i_word2 <= r.w2;
    i_pc    <= r.pc;
    dly     <= r.dly;
    @(posedge i_clk);
    i_start <= 1'b0;
    wait_done();
  endtask

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  // Free-running 40 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Reset, table of instructions, then the awkward cases
  initial
  begin
    i_nrst = 1'b0;
    i_start = 1'b0;
    i_instr = 16'h0000;
    i_word2 = 16'h0000;
    i_pc = 15'h0000;
    dly = 4'h0;
    n_mismatch = 0;
    samples_checked = 0;
    e_acc = 16'h0000;
    e_sec = 16'h0000;
    e_idx = 16'h0000;
    i_mem.mem[15'h0645] = 16'h1234;
    i_mem.mem[15'h1010] = 16'h5678;
    i_mem.mem[15'h0120] = 16'h0200;
    i_mem.mem[15'h0030] = 16'h0300;
    i_mem.mem[15'h2345] = 16'h9abc;
    i_mem.mem[15'h0500] = 16'hdef0;
    i_mem.mem[15'h0600] = 16'h0700;
    i_mem.mem[15'h0700] = 16'h0042;
    i_mem.mem[15'h0142] = 16'h1357;
    // Pointer chains that would land on a wrong word if cut short
    for (int i = 0; i < 5; i++)
      i_mem.mem[15'h0040 + i] = 16'h8041 + 16'(i);
    for (int i = 0; i < 4; i++)
      i_mem.mem[15'h0050 + i] = 16'h8051 + 16'(i);
    i_mem.mem[15'h0045] = 16'h0c0c;
    i_mem.mem[15'h0c0c] = 16'hbad1;
    i_mem.mem[15'h0054] = 16'h0d0d;
    i_mem.mem[15'h0d0d] = 16'hbad2;
    // First clock edge applies reset even if the time-zero event was missed
    @(posedge i_clk);
    @(negedge i_clk);
    check("busy in reset", {15'h0, busy}, 16'h0000);
    check("acc in reset", acc, lsu_pkg::REG_RESET);
    @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (rows[n])
    begin
      wr_before = i_mem.wr_count;
      run(rows[n]);
      check("illegal", {15'h0, illegal},
            {15'h0, rows[n].kind == 3'h0});
      case (rows[n].kind)
        3'h1: e_acc = rows[n].val;
        3'h2: e_sec = rows[n].val;
        3'h3: e_idx = rows[n].val;
        default: ;
      endcase
      check("acc", acc, e_acc);
      check("sec", sec, e_sec);
      check("idx", idx, e_idx);
      check("writes", 16'(i_mem.wr_count - wr_before),
            {15'h0, rows[n].kind == 3'h5});
      if (rows[n].kind == 3'h5)
        check("stored", i_mem.mem[rows[n].addr], rows[n].val);
    end
    // Start held high while busy must not launch a second instruction
    @(posedge i_clk);
    i_start <= 1'b1;
    i_instr <= 16'h1645;
    dly     <= 4'h6;
    @(posedge i_clk);
    i_instr <= 16'h0c08;
    i_word2 <= 16'heeee;
    repeat (2) @(posedge i_clk);
    i_start <= 1'b0;
    // Operand still outstanding: a wrongly taken literal would show here
    @(negedge i_clk);
    check("acc while busy", acc, e_acc);
    wait_done();
    check("acc after ignored start", acc, 16'h1234);
    repeat (3) @(negedge i_clk);
    check("busy after ignored start", {15'h0, busy}, 16'h0000);
    // Reset in the middle of a slow store
    wr_before = i_mem.wr_count;
    @(posedge i_clk);
    i_start <= 1'b1;
    i_instr <= 16'h5c04;
    dly     <= 4'h8;
    @(posedge i_clk);
    i_start <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b0;
    @(negedge i_clk);
    check("req in reset", {15'h0, mem_req}, 16'h0000);
    check("acc in reset", acc, lsu_pkg::REG_RESET);
    check("writes in reset", 16'(i_mem.wr_count - wr_before),
          16'h0000);
    @(posedge i_clk);
    i_nrst <= 1'b1;
    run(rows[2]);
    check("idx after reset", idx, 16'h0100);
    check("sec after reset", sec, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
